/* src/pwr_seq_pkg.sv */
// Shared constants and state types for the power toggle / hard restart link.
// Assumes one 40 MHz core clock on both ends of the link.
package pwr_seq_pkg;

    // Core clock
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;

    // Pad pulse minimums
    localparam int unsigned ON_PULSE_MS   = 1000;
    localparam int unsigned OFF_PULSE_MS  = 2000;
    localparam int unsigned RST_PULSE_MS  = 200;
    localparam int unsigned ON_PULSE_CYC  = ON_PULSE_MS * CYC_PER_MS;
    localparam int unsigned OFF_PULSE_CYC = OFF_PULSE_MS * CYC_PER_MS;
    localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CYC_PER_MS;

    // Internal power-up settling of the module
    localparam int unsigned BOOT_TIME_US  = 1000;
    localparam int unsigned BOOT_CYC      = BOOT_TIME_US * CYC_PER_US;

    // Counter width covers the longest pulse
    localparam int unsigned CNT_W         = 28;
    typedef logic [CNT_W-1:0] cnt_t;

    localparam cnt_t CNT_ZERO = 28'h0000000;
    localparam cnt_t CNT_ONE  = 28'h0000001;

    typedef enum logic [3:0] {
        DEV_OFF    = 4'h1,
        DEV_BOOT   = 4'h2,
        DEV_ON     = 4'h4,
        DEV_DETACH = 4'h8
    } devState_t;

    typedef enum logic [5:0] {
        HOST_IDLE      = 6'h01,
        HOST_ON_PULSE  = 6'h02,
        HOST_CUT_USB   = 6'h04,
        HOST_OFF_PULSE = 6'h08,
        HOST_WAIT_DOWN = 6'h10,
        HOST_RST_PULSE = 6'h20
    } hostState_t;

endpackage

/* src/pwr_link_if.sv */
// Pad-level link between host sequencer and module power sequencer.
// Assumes open-collector pads: only the host pulls low, the module side pulls up.
`timescale 1ns/100ps
interface pwr_link_if;
    logic togglePadOut;
    logic togglePadOe;
    logic restartPadOut;
    logic restartPadOe;
    logic togglePadLevel;
    logic restartPadLevel;
    logic usbBusPower;
    logic powerGoodMonitor;

    // Internal pull-ups keep both pads high while nobody pulls them
    assign togglePadLevel  = togglePadOe ? togglePadOut : 1'b1;
    assign restartPadLevel = restartPadOe ? restartPadOut : 1'b1;

    modport host (
        output togglePadOut,
        output togglePadOe,
        output restartPadOut,
        output restartPadOe,
        output usbBusPower,
        input  powerGoodMonitor
    );

    modport dev (
        input  togglePadLevel,
        input  restartPadLevel,
        input  usbBusPower,
        output powerGoodMonitor
    );
endinterface

/* src/module_pwr_device.sv */
// Module-side power sequencer: toggle pad, hard restart pad, USB bus power,
// battery and charge sense, power-good monitor and network detach handshake.
// Assumes pads arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
module module_pwr_device #(
    parameter int unsigned ON_CYC   = pwr_seq_pkg::ON_PULSE_CYC,
    parameter int unsigned OFF_CYC  = pwr_seq_pkg::OFF_PULSE_CYC,
    parameter int unsigned RST_CYC  = pwr_seq_pkg::RST_PULSE_CYC,
    parameter int unsigned BOOT_LEN = pwr_seq_pkg::BOOT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    pwr_link_if.dev          link,
    input  wire logic        batteryPresent,
    input  wire logic        chargePadPower,
    input  wire logic        detachAck,
    output logic             moduleOn,
    output logic             detachReq,
    output pwr_seq_pkg::devState_t powerState
);
    import pwr_seq_pkg::*;

    localparam cnt_t ON_MIN   = cnt_t'(ON_CYC);
    localparam cnt_t OFF_MIN  = cnt_t'(OFF_CYC);
    localparam cnt_t RST_MIN  = cnt_t'(RST_CYC);
    localparam cnt_t BOOT_END = cnt_t'(BOOT_LEN - 1);
    // Toggle counter saturates at the longer of the two thresholds
    localparam cnt_t TOG_SAT  = (OFF_MIN > ON_MIN) ? OFF_MIN : ON_MIN;

    typedef struct packed {
        devState_t  state;
        logic [1:0] togSync;
        logic       togPrev;
        logic [1:0] rstSync;
        logic       rstPrev;
        logic [1:0] usbSync;
        logic [1:0] batSync;
        logic [1:0] chgSync;
        logic [1:0] ackSync;
        cnt_t       togCnt;
        cnt_t       rstCnt;
        cnt_t       bootCnt;
        logic       powerGood;
        logic       detachReq;
        logic       moduleOn;
    } devReg_t;

    localparam devReg_t DEV_RESET = '{
        state:     DEV_OFF,
        togSync:   2'h3,
        togPrev:   1'b1,
        rstSync:   2'h3,
        rstPrev:   1'b1,
        usbSync:   2'h0,
        batSync:   2'h0,
        chgSync:   2'h0,
        ackSync:   2'h0,
        togCnt:    CNT_ZERO,
        rstCnt:    CNT_ZERO,
        bootCnt:   CNT_ZERO,
        powerGood: 1'b0,
        detachReq: 1'b0,
        moduleOn:  1'b0
    };

    devReg_t q;
    devReg_t d;

    logic togLow;
    logic togRelease;
    logic rstLow;
    logic rstRelease;
    logic usbOn;
    logic batOn;
    logic chgOn;
    logic ackOn;
    logic onPulse;
    logic offPulse;
    logic restartPulse;
    logic autoPowerOn;

    always_comb begin
        d = q;

        // Two-flop synchronisers; only the second stage is read below
        d.togSync = {q.togSync[0], link.togglePadLevel};
        d.rstSync = {q.rstSync[0], link.restartPadLevel};
        d.usbSync = {q.usbSync[0], link.usbBusPower};
        d.batSync = {q.batSync[0], batteryPresent};
        d.chgSync = {q.chgSync[0], chargePadPower};
        d.ackSync = {q.ackSync[0], detachAck};
        d.togPrev = q.togSync[1];
        d.rstPrev = q.rstSync[1];

        togLow     = !q.togSync[1];
        rstLow     = !q.rstSync[1];
        togRelease = q.togSync[1] && !q.togPrev;
        rstRelease = q.rstSync[1] && !q.rstPrev;
        usbOn      = q.usbSync[1];
        batOn      = q.batSync[1];
        chgOn      = q.chgSync[1];
        ackOn      = q.ackSync[1];

        // Low-time counters hold their value through the release cycle
        if (togLow) begin
            if (q.togCnt < TOG_SAT) begin
                d.togCnt = q.togCnt + CNT_ONE;
            end
        end else begin
            d.togCnt = CNT_ZERO;
        end
        if (rstLow) begin
            if (q.rstCnt < RST_MIN) begin
                d.rstCnt = q.rstCnt + CNT_ONE;
            end
        end else begin
            d.rstCnt = CNT_ZERO;
        end

        // Pulses act at release only, never while the pad is held
        onPulse      = togRelease && (q.togCnt >= ON_MIN);
        offPulse     = togRelease && (q.togCnt >= OFF_MIN);
        restartPulse = rstRelease && (q.rstCnt >= RST_MIN);
        autoPowerOn  = batOn && (usbOn || chgOn);

        case (q.state)
            DEV_OFF: begin
                d.powerGood = 1'b0;
                d.moduleOn  = 1'b0;
                d.detachReq = 1'b0;
                if (onPulse || autoPowerOn) begin
                    d.state   = DEV_BOOT;
                    d.bootCnt = CNT_ZERO;
                end
            end
            DEV_BOOT: begin
                d.bootCnt = q.bootCnt + CNT_ONE;
                if (restartPulse) begin
                    d.bootCnt = CNT_ZERO;
                end else if (q.bootCnt >= BOOT_END) begin
                    d.state     = DEV_ON;
                    d.powerGood = 1'b1;
                    d.moduleOn  = 1'b1;
                end
            end
            DEV_ON: begin
                if (restartPulse) begin
                    // Unconditional: no detach, straight back to power-up
                    d.state     = DEV_BOOT;
                    d.bootCnt   = CNT_ZERO;
                    d.powerGood = 1'b0;
                    d.moduleOn  = 1'b0;
                end else if (offPulse && !usbOn) begin
                    // USB power present blocks shutdown entirely
                    d.state     = DEV_DETACH;
                    d.detachReq = 1'b1;
                end
            end
            DEV_DETACH: begin
                if (restartPulse) begin
                    d.state     = DEV_BOOT;
                    d.bootCnt   = CNT_ZERO;
                    d.detachReq = 1'b0;
                    d.powerGood = 1'b0;
                    d.moduleOn  = 1'b0;
                end else if (ackOn) begin
                    d.state     = DEV_OFF;
                    d.detachReq = 1'b0;
                    d.powerGood = 1'b0;
                    d.moduleOn  = 1'b0;
                end
            end
            default: begin
                d = DEV_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= DEV_RESET;
        end else begin
            q <= d;
        end
    end

    assign link.powerGoodMonitor = q.powerGood;
    assign moduleOn              = q.moduleOn;
    assign detachReq             = q.detachReq;
    assign powerState            = q.state;

endmodule

/* src/module_pwr_host.sv */
// Host-side sequencer: open-collector toggle and restart pulses, USB bus
// power switch gated by the power-good monitor.
// Assumes power-good arrives asynchronously from the module.
`timescale 1ns/100ps
module module_pwr_host #(
    parameter int unsigned ON_CYC  = pwr_seq_pkg::ON_PULSE_CYC,
    parameter int unsigned OFF_CYC = pwr_seq_pkg::OFF_PULSE_CYC,
    parameter int unsigned RST_CYC = pwr_seq_pkg::RST_PULSE_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    pwr_link_if.host         link,
    input  wire logic        cmdOn,
    input  wire logic        cmdOff,
    input  wire logic        cmdRestart,
    input  wire logic        usbWanted,
    output logic             busy,
    output logic             moduleIsOn
);
    import pwr_seq_pkg::*;

    localparam cnt_t ON_END  = cnt_t'(ON_CYC - 1);
    localparam cnt_t OFF_END = cnt_t'(OFF_CYC - 1);
    localparam cnt_t RST_END = cnt_t'(RST_CYC - 1);

    typedef struct packed {
        hostState_t state;
        logic [1:0] pgSync;
        cnt_t       cnt;
        logic       toggleOe;
        logic       restartOe;
        logic       padLow;
        logic       usbPower;
        logic       busy;
        logic       moduleIsOn;
    } hostReg_t;

    localparam hostReg_t HOST_RESET = '{
        state:      HOST_IDLE,
        pgSync:     2'h0,
        cnt:        CNT_ZERO,
        toggleOe:   1'b0,
        restartOe:  1'b0,
        padLow:     1'b0,
        usbPower:   1'b0,
        busy:       1'b0,
        moduleIsOn: 1'b0
    };

    hostReg_t q;
    hostReg_t d;
    logic     pg;

    always_comb begin
        d = q;
        d.pgSync     = {q.pgSync[0], link.powerGoodMonitor};
        pg           = q.pgSync[1];
        d.moduleIsOn = pg;
        d.padLow     = 1'b0;
        d.cnt        = q.cnt + CNT_ONE;
        case (q.state)
            HOST_IDLE: begin
                d.busy     = 1'b0;
                d.cnt      = CNT_ZERO;
                d.usbPower = usbWanted && pg;
                if (cmdRestart) begin
                    d.state     = HOST_RST_PULSE;
                    d.restartOe = 1'b1;
                    d.busy      = 1'b1;
                end else if (cmdOn && !pg) begin
                    d.state    = HOST_ON_PULSE;
                    d.toggleOe = 1'b1;
                    d.busy     = 1'b1;
                end else if (cmdOff && pg) begin
                    d.state    = HOST_CUT_USB;
                    d.usbPower = 1'b0;
                    d.busy     = 1'b1;
                end
            end
            HOST_ON_PULSE: begin
                if (q.cnt >= ON_END) begin
                    d.toggleOe = 1'b0;
                    d.state    = HOST_IDLE;
                end
            end
            HOST_CUT_USB: begin
                // USB power already low one cycle before the pad falls
                d.state    = HOST_OFF_PULSE;
                d.toggleOe = 1'b1;
                d.cnt      = CNT_ZERO;
            end
            HOST_OFF_PULSE: begin
                if (q.cnt >= OFF_END) begin
                    d.toggleOe = 1'b0;
                    d.state    = HOST_WAIT_DOWN;
                end
            end
            HOST_WAIT_DOWN: begin
                // USB power stays off until power-good drops
                if (!pg) begin
                    d.state = HOST_IDLE;
                end else if (cmdRestart) begin
                    d.state     = HOST_RST_PULSE;
                    d.restartOe = 1'b1;
                    d.cnt       = CNT_ZERO;
                end
            end
            HOST_RST_PULSE: begin
                d.usbPower = 1'b0;
                if (q.cnt >= RST_END) begin
                    d.restartOe = 1'b0;
                    d.state     = HOST_IDLE;
                end
            end
            default: begin
                d = HOST_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= HOST_RESET;
        end else begin
            q <= d;
        end
    end

    assign link.togglePadOut  = q.padLow;
    assign link.restartPadOut = q.padLow;
    assign link.togglePadOe   = q.toggleOe;
    assign link.restartPadOe  = q.restartOe;
    assign link.usbBusPower   = q.usbPower;
    assign busy               = q.busy;
    assign moduleIsOn         = q.moduleIsOn;

endmodule

/* testbench/pwr_link_props.sv */
// Checker on the pad link between the host and module power sequencers.
// Assumes the testbench instantiates it beside the link interface.
`timescale 1ns/100ps
module pwr_link_props #(
    parameter int unsigned ON_CYC  = 20,
    parameter int unsigned OFF_CYC = 40,
    parameter int unsigned RST_CYC = 10
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic togglePadOut,
    input wire logic togglePadOe,
    input wire logic restartPadOut,
    input wire logic restartPadOe,
    input wire logic togglePadLevel,
    input wire logic restartPadLevel,
    input wire logic usbBusPower,
    input wire logic powerGoodMonitor
);
    int unsigned togLen_q;
    int unsigned rstLen_q;

    // Pulse lengths exceed repetition limits, so count them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            togLen_q <= 0;
            rstLen_q <= 0;
        end else begin
            togLen_q <= togglePadOe ? togLen_q + 1 : 0;
            rstLen_q <= restartPadOe ? rstLen_q + 1 : 0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence onRelease;
        $fell(togglePadOe) && !powerGoodMonitor;
    endsequence
    sequence offRelease;
        $fell(togglePadOe) && powerGoodMonitor;
    endsequence

    AST_TOGGLE_OPEN_COLLECTOR: assert property (togglePadOe |-> !togglePadOut)
        else $error("toggle pad driven high");
    AST_RESTART_OPEN_COLLECTOR: assert property (restartPadOe |-> !restartPadOut)
        else $error("restart pad driven high");
    AST_RESTART_PULLED_UP: assert property (!restartPadOe |-> restartPadLevel)
        else $error("restart pad low while released");
    AST_ON_PULSE_LEN: assert property (onRelease |-> togLen_q == ON_CYC)
        else $error("on pulse length wrong");
    AST_OFF_PULSE_LEN: assert property (offRelease |-> togLen_q == OFF_CYC)
        else $error("off pulse length wrong");
    AST_RESTART_PULSE_LEN: assert property ($fell(restartPadOe) |-> rstLen_q == RST_CYC)
        else $error("restart pulse length wrong");
    AST_USB_CUT_BEFORE_OFF: assert property ($rose(togglePadOe) |-> !usbBusPower)
        else $error("usb power present at toggle pulse");
    AST_USB_ONLY_WHEN_ON: assert property ($rose(usbBusPower) |-> powerGoodMonitor)
        else $error("usb power applied while module off");
    AST_NO_OFF_WHILE_HELD: assert property (!togglePadLevel |-> !$fell(powerGoodMonitor))
        else $error("power good fell while toggle held");
    AST_POWER_GOOD_RISES: assert property (onRelease |-> ##[2:24] powerGoodMonitor)
        else $error("power good not raised after on pulse");
    AST_POWER_GOOD_FALLS: assert property (offRelease |-> ##[4:40] !powerGoodMonitor)
        else $error("power good not lowered after off pulse");
endmodule

/* testbench/tb.sv */
// Testbench joining host and module sequencers over the pad link.
// Assumes shortened pulse counts; the network detach acknowledge comes from here.
`timescale 1ns/100ps
module tb;
    import pwr_seq_pkg::*;
    localparam int unsigned ON_CYC  = 20;
    localparam int unsigned OFF_CYC = 40;
    localparam int unsigned RST_CYC = 10;

    logic      core_clk = 1'b0;
    logic      rst_n, cmdOn, cmdOff, cmdRestart, usbWanted;
    logic      batteryPresent, chargePadPower, detachAck;
    logic      busy, moduleIsOn, moduleOn, detachReq;
    devState_t powerState;
    int        errCount, nCompared, cyc, togLow, rstLow, modelOn;
    int        expQ[$];
    int        seq[$] = {1, 0, 0, 2, 1, 2, 0, 1};

    always #12.5 core_clk = ~core_clk;

    pwr_link_if link();
    module_pwr_host #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .RST_CYC(RST_CYC)) u_module_pwr_host (.core_clk,
        .rst_n, .link(link.host), .cmdOn, .cmdOff, .cmdRestart, .usbWanted, .busy, .moduleIsOn);
    module_pwr_device #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .RST_CYC(RST_CYC), .BOOT_LEN(8))
        u_module_pwr_device (.core_clk, .rst_n, .link(link.dev), .batteryPresent, .chargePadPower,
        .detachAck, .moduleOn, .detachReq, .powerState);
    pwr_link_props #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .RST_CYC(RST_CYC)) u_pwr_link_props (.core_clk,
        .rst_n, .togglePadOut(link.togglePadOut), .togglePadOe(link.togglePadOe),
        .restartPadOut(link.restartPadOut), .restartPadOe(link.restartPadOe),
        .togglePadLevel(link.togglePadLevel), .restartPadLevel(link.restartPadLevel),
        .usbBusPower(link.usbBusPower), .powerGoodMonitor(link.powerGoodMonitor));

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic closeOut;
        if (errCount == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Pulse widths measured on the resolved pads, sampled mid-cycle where they are settled
    always @(negedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            errCount++;
            closeOut();
        end else begin
            if (link.togglePadLevel === 1'b0) togLow++;
            else if (togLow > 0) begin
                check("toggle low", togLow[7:0], 8'(expQ.pop_front()));
                togLow = 0;
            end
            if (link.restartPadLevel === 1'b0) rstLow++;
            else if (rstLow > 0) begin
                check("restart low", rstLow[7:0], 8'(RST_CYC));
                rstLow = 0;
            end
        end
    end

    // Network answers the detach after a random delay
    initial begin
        detachAck = 1'b0;
        forever begin
            @(posedge detachReq);
            #2;
            check("at detach", {5'h00, link.togglePadLevel, link.usbBusPower, link.powerGoodMonitor}, 8'h05);
            repeat ($urandom_range(1, 6)) @(posedge core_clk);
            #2 detachAck = 1'b1;
            @(negedge detachReq);
            #2 detachAck = 1'b0;
        end
    end

    // 0 on, 1 off, 2 restart
    task automatic runCmd(int c);
        bit take;
        take = (c == 2) || (c == 0 && modelOn == 0) || (c == 1 && modelOn == 1);
        if (take && c != 2) expQ.push_back(c == 0 ? ON_CYC : OFF_CYC);
        @(posedge core_clk);
        #2;
        cmdOn = (c == 0);
        cmdOff = (c == 1);
        cmdRestart = (c == 2);
        @(posedge core_clk);
        #2;
        {cmdOn, cmdOff, cmdRestart} = 3'h0;
        check("busy", {7'h00, busy}, {7'h00, take});
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
        for (int i = 0; i < 50 && c == 2 && modelOn == 1 && link.powerGoodMonitor !== 1'b0; i++)
            @(negedge core_clk);
        if (take && c != 2) modelOn = 1 - modelOn;
        for (int i = 0; i < 400 && (moduleIsOn !== modelOn[0] || powerState !== (modelOn ? DEV_ON : DEV_OFF));
             i++) @(negedge core_clk);
        check("host view", {7'h00, moduleIsOn}, 8'(modelOn));
        check("module on", {7'h00, moduleOn}, 8'(modelOn));
        check("state", {4'h0, powerState}, modelOn ? 8'h04 : 8'h01);
    endtask

    initial begin
        void'($urandom(73534));
        {rst_n, cmdOn, cmdOff, cmdRestart, usbWanted, chargePadPower} = 6'h00;
        batteryPresent = 1'b1;
        repeat (2) @(posedge core_clk);
        #2 rst_n = 1'b1;
        check("reset outputs", {link.togglePadLevel, link.restartPadLevel, link.usbBusPower,
              link.powerGoodMonitor, busy, detachReq, moduleOn, moduleIsOn}, 8'hC0);
        check("reset state", {4'h0, powerState}, 8'h01);
        usbWanted = 1'b1;
        repeat (4) seq.push_back($urandom_range(0, 2));
        seq.push_back(1);
        foreach (seq[i]) runCmd(seq[i]);
        // Battery plus charge power must bring the module up alone
        @(posedge core_clk);
        #2 chargePadPower = 1'b1;
        for (int i = 0; i < 200 && link.powerGoodMonitor !== 1'b1; i++) @(negedge core_clk);
        check("charge boot", {4'h0, powerState}, 8'h04);
        check("charge power good", {7'h00, link.powerGoodMonitor}, 8'h01);
        closeOut();
    end
endmodule
